/* src/pbmc_pkg.sv */
// Package for the basic mode control register block of an integrated PHY.
// Assumes a classic Wishbone slave with 32-bit data and one 250 MHz clock.
`default_nettype none
package pbmc_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] PBMC_OFF_CONTROL = 8'h00;
  localparam logic [7:0] PBMC_OFF_NEGOTIATE = 8'h04;
  localparam logic [7:0] PBMC_OFF_STATUS = 8'h08;
  localparam logic [15:0] PBMC_CONTROL_RESET = 16'h3100;
  localparam logic [15:0] PBMC_CONTROL_WMASK = 16'hFB80;
  // ==========================================================================
  // Field positions
  localparam int PBMC_BIT_RESET = 15;
  localparam int PBMC_BIT_LOOPBACK = 14;
  localparam int PBMC_BIT_SPEED = 13;
  localparam int PBMC_BIT_AUTONEG = 12;
  localparam int PBMC_BIT_POWER_DOWN = 11;
  localparam int PBMC_BIT_RESTART = 9;
  localparam int PBMC_BIT_DUPLEX = 8;
  localparam int PBMC_BIT_COL_TEST = 7;
  // ==========================================================================
  // Timing
  localparam int PBMC_CLK_MHZ = 250;
  localparam int PBMC_RESET_NS = 400;
  localparam logic [7:0] PBMC_RESET_CYCLES = 8'(PBMC_RESET_NS * PBMC_CLK_MHZ / 1000);
  localparam int PBMC_LOOP_DEAD_MS = 720;
  localparam int PBMC_LOOP_DEAD_CYCLES = PBMC_LOOP_DEAD_MS * PBMC_CLK_MHZ * 1000;
  localparam logic [7:0] PBMC_AN_START_CYCLES = 8'h04;
  // Negotiation engine states.
  typedef enum logic [1:0] {PBMC_AN_IDLE, PBMC_AN_START, PBMC_AN_RUN} pbmc_an_type;
endpackage : pbmc_pkg
`default_nettype wire

/* src/pbmc_sync.sv */
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk.
`default_nettype none
module pbmc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Level
  input wire logic async_in,
  output logic sync_out
);
  logic stage1;

  // ==========================================================================
  // Stage one is read only by stage two.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pbmc_sync
`default_nettype wire

/* src/pbmc_count.sv */
// Down counter that reports busy while a loaded count runs out.
// Assumes a load pulse from logic on the same clock.
`default_nettype none
module pbmc_count (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic [7:0] count,
  output logic busy
);
  logic [7:0] remain;

  // ==========================================================================
  // Load wins over counting, so a repeated start restarts the wait.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      remain <= 8'h00;
    end
    else if (load)
    begin
      remain <= count;
    end
    else if (remain != 8'h00)
    begin
      remain <= remain - 8'h01;
    end
  end

  assign busy = (remain != 8'h00);
endmodule : pbmc_count
`default_nettype wire

/* src/pbmc_top.sv */
// Basic mode control register of an integrated Ethernet PHY, Wishbone slave.
// Assumes a classic Wishbone master on clk; tx_en and the negotiation result
// arrive from other clock domains and are synchronised here.
// Summary of operation
// - Writing one to reset returns every PHY control field to default.
// - Reset self-clears and reads one while the reset process runs.
// - Loopback field enables loopback; 100 Mbps loopback has dead time.
// - Without negotiation, speed field picks 100 Mbps at one, 10 otherwise.
// - With negotiation on, speed reads the negotiated speed.
// - Negotiation enable defaults one; selects reported or forced speed/duplex.
// - Power down field powers down all but the oscillator.
// - Restart reruns negotiation, reads one until negotiation really starts.
// - Restart does nothing while negotiation is disabled.
// - Writing zero to restart does not disturb running negotiation.
// - Without negotiation, duplex field one is full, zero half.
// - With negotiation on, duplex reads the negotiated duplex.
// - Collision test drives collision whenever transmit enable is high.
// - Control register at offset zero, reset value 3100H.
`default_nettype none
module pbmc_top
  import pbmc_pkg::*;
#(
  parameter int LOOP_DEAD_CYCLES = PBMC_LOOP_DEAD_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Media side
  input wire logic tx_en,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic an_done,
  output logic col,
  // PHY controls
  output logic phy_soft_reset,
  output logic loopback,
  output logic rx_dead,
  output logic speed_100,
  output logic full_duplex,
  output logic power_down,
  output logic an_start
);
  logic [15:0] phy_basic_control;
  logic reset_busy;
  logic reset_load;
  logic restart_pending;
  logic start_busy;
  logic start_load;
  logic tx_en_s;
  logic an_speed_s;
  logic an_duplex_s;
  logic an_done_s;
  logic [31:0] dead_count;
  pbmc_an_type an_state;
  logic wr_ctl;
  logic [15:0] wdata;
  logic [15:0] next_control;
  logic [15:0] read_control;

  // ==========================================================================
  // Synchronisers for inputs from other domains.
  pbmc_sync u_sync_tx (.clk(clk), .rst(rst), .async_in(tx_en), .sync_out(tx_en_s));
  pbmc_sync u_sync_sp (.clk(clk), .rst(rst), .async_in(an_speed_100), .sync_out(an_speed_s));
  pbmc_sync u_sync_dx (.clk(clk), .rst(rst), .async_in(an_full_duplex), .sync_out(an_duplex_s));
  pbmc_sync u_sync_dn (.clk(clk), .rst(rst), .async_in(an_done), .sync_out(an_done_s));

  // ==========================================================================
  // Bus decode: a write takes effect on the acknowledging edge.
  assign wr_ctl = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                  && (wb_adr_i == PBMC_OFF_CONTROL);

  // Byte enables merge the written lanes over the stored value.
  always_comb
  begin
    wdata = phy_basic_control;
    if (wb_sel_i[0])
    begin
      wdata[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1])
    begin
      wdata[15:8] = wb_dat_i[15:8];
    end
  end

  // Next value: reserved bits and self-clearing bits are never stored.
  always_comb
  begin
    next_control = phy_basic_control;
    if (wr_ctl)
    begin
      next_control = wdata & PBMC_CONTROL_WMASK;
      next_control[PBMC_BIT_RESET] = 1'b0;
      next_control[PBMC_BIT_RESTART] = 1'b0;
    end
  end

  // ==========================================================================
  // Control register; a software reset restores the default value.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      phy_basic_control <= PBMC_CONTROL_RESET;
    end
    else if (reset_load || reset_busy)
    begin
      phy_basic_control <= PBMC_CONTROL_RESET;
    end
    else
    begin
      phy_basic_control <= next_control;
    end
  end

  // Software reset starts a timed reset process.
  assign reset_load = wr_ctl && wb_sel_i[1] && wb_dat_i[PBMC_BIT_RESET];
  pbmc_count u_reset_cnt (
    .clk(clk),
    .rst(rst),
    .load(reset_load),
    .count(PBMC_RESET_CYCLES),
    .busy(reset_busy)
  );
  assign phy_soft_reset = reset_busy;

  // ==========================================================================
  // Restart request: held until the engine has started, ignored without
  // negotiation; a written zero leaves it and the engine alone.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      restart_pending <= 1'b0;
    end
    else if (reset_load || reset_busy)
    begin
      restart_pending <= 1'b0;
    end
    else if (wr_ctl && wb_sel_i[1] && wb_dat_i[PBMC_BIT_RESTART]
             && next_control[PBMC_BIT_AUTONEG])
    begin
      restart_pending <= 1'b1;
    end
    else if (an_state == PBMC_AN_START && !start_busy)
    begin
      restart_pending <= 1'b0;
    end
  end

  assign start_load = restart_pending && an_state != PBMC_AN_START;
  pbmc_count u_start_cnt (
    .clk(clk),
    .rst(rst),
    .load(start_load),
    .count(PBMC_AN_START_CYCLES),
    .busy(start_busy)
  );

  // Negotiation sequencer.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      an_state <= PBMC_AN_IDLE;
    end
    else if (!phy_basic_control[PBMC_BIT_AUTONEG] || reset_busy)
    begin
      an_state <= PBMC_AN_IDLE;
    end
    else
    begin
      case (an_state)
        PBMC_AN_IDLE:
        begin
          if (restart_pending)
          begin
            an_state <= PBMC_AN_START;
          end
        end
        PBMC_AN_START:
        begin
          if (!start_busy)
          begin
            an_state <= PBMC_AN_RUN;
          end
        end
        PBMC_AN_RUN:
        begin
          if (restart_pending)
          begin
            an_state <= PBMC_AN_START;
          end
          else if (an_done_s)
          begin
            an_state <= PBMC_AN_IDLE;
          end
        end
        default:
        begin
          an_state <= PBMC_AN_IDLE;
        end
      endcase
    end
  end

  assign an_start = (an_state == PBMC_AN_START) && !start_busy;

  // ==========================================================================
  // Loopback dead time in 100 Mbps operation.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dead_count <= 32'h00000000;
    end
    else if (wr_ctl && wdata[PBMC_BIT_LOOPBACK] && !loopback && speed_100)
    begin
      dead_count <= 32'(LOOP_DEAD_CYCLES);
    end
    else if (dead_count != 32'h00000000)
    begin
      dead_count <= dead_count - 32'h00000001;
    end
  end

  // ==========================================================================
  // Effective controls and collision test.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      loopback <= 1'b0;
      power_down <= 1'b0;
      speed_100 <= 1'b1;
      full_duplex <= 1'b1;
      col <= 1'b0;
      rx_dead <= 1'b0;
    end
    else
    begin
      loopback <= phy_basic_control[PBMC_BIT_LOOPBACK];
      power_down <= phy_basic_control[PBMC_BIT_POWER_DOWN];
      speed_100 <= phy_basic_control[PBMC_BIT_AUTONEG] ? an_speed_s
                   : phy_basic_control[PBMC_BIT_SPEED];
      full_duplex <= phy_basic_control[PBMC_BIT_AUTONEG] ? an_duplex_s
                     : phy_basic_control[PBMC_BIT_DUPLEX];
      col <= phy_basic_control[PBMC_BIT_COL_TEST] && tx_en_s;
      rx_dead <= (dead_count != 32'h00000000);
    end
  end

  // Read view: live reset and restart, negotiated speed and duplex.
  always_comb
  begin
    read_control = phy_basic_control;
    read_control[PBMC_BIT_RESET] = reset_busy;
    read_control[PBMC_BIT_RESTART] = restart_pending;
    if (phy_basic_control[PBMC_BIT_AUTONEG])
    begin
      read_control[PBMC_BIT_SPEED] = an_speed_s;
      read_control[PBMC_BIT_DUPLEX] = an_duplex_s;
    end
  end

  // ==========================================================================
  // Wishbone answer: one wait state, unmapped addresses read zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
        PBMC_OFF_CONTROL: wb_dat_o <= {16'h0000, read_control};
        PBMC_OFF_NEGOTIATE: wb_dat_o <= {29'h00000000, an_done_s, an_duplex_s, an_speed_s};
        PBMC_OFF_STATUS: wb_dat_o <= {28'h0000000, rx_dead, an_start, start_busy,
                                       reset_busy};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule : pbmc_top
`default_nettype wire

/* bench/pbmc_assertions.sv */
// Checker for the basic mode control register block, bound to pbmc_top.
// Assumes it sees only the top ports and one clock domain.
`default_nettype none
module pbmc_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Media side and controls
  input wire logic tx_en,
  input wire logic col,
  input wire logic phy_soft_reset,
  input wire logic loopback,
  input wire logic power_down
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Sequences
  // A write to the control register is taken at this edge.
  sequence s_ctl_wr;
    wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
  endsequence
  // The taken write also asks for a software reset.
  sequence s_rst_wr;
    s_ctl_wr ##0 wb_dat_i[15];
  endsequence
  // ==========================================================================
  // Assertions
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after a request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RSVD_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
    |-> wb_dat_o[10] == 1'b0 && wb_dat_o[6:0] == 7'h00)
    else $error("reserved control bits not zero");
  AST_SOFT_RST: assert property (s_rst_wr |-> ##[1:2] phy_soft_reset [*8])
    else $error("software reset not held");
  AST_RST_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00
    && phy_soft_reset && $past(phy_soft_reset) |-> wb_dat_o[15])
    else $error("reset bit not read as one");
  AST_LOOP: assert property (s_ctl_wr ##0 (wb_dat_i[14] && !wb_dat_i[15])
    |-> ##[1:2] loopback)
    else $error("loopback not enabled");
  AST_RST_CLR: assert property ($rose(phy_soft_reset) |-> ##2 (!loopback && !power_down))
    else $error("controls not restored by reset");
  AST_COL: assert property (col |-> $past(tx_en, 2) || $past(tx_en, 3) || $past(tx_en, 4))
    else $error("collision without transmit enable");
endmodule : pbmc_assertions
bind pbmc_top pbmc_assertions u_pbmc_assertions (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_en(tx_en), .col(col),
  .phy_soft_reset(phy_soft_reset), .loopback(loopback), .power_down(power_down));
`default_nettype wire

/* bench/pbmc_partner.sv */
// Negotiation engine model facing the control block.
// Assumes the bench chooses the result that it reports.
`default_nettype none
module pbmc_partner (
  // Clock
  input wire logic clk,
  // Control
  input wire logic an_start,
  input wire logic want_100,
  input wire logic want_full,
  // Result
  output logic an_speed_100 = 1'b1,
  output logic an_full_duplex = 1'b1,
  output logic an_done = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  int left = 0;
  // Reports the chosen result; done rises a few cycles after each start.
  always @(posedge clk)
  begin
    an_speed_100 <= want_100;
    an_full_duplex <= want_full;
    left <= an_start ? 6 : (left > 0 ? left - 1 : 0);
    an_done <= an_start ? 1'b0 : (an_done || left == 1);
  end
endmodule : pbmc_partner
`default_nettype wire

/* bench/pbmc_top_tb.sv */
// Self-checking bench for the basic mode control register block.
// Assumes a 250 MHz clock and a short loopback dead time.
`default_nettype none
module pbmc_top_tb;
  import pbmc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, tx_en = 0, w100 = 1, wfull = 1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, col, psr, lb, rxd, sp, fd, pd, ans, a100, afull, adone;
  int failures = 0, n_compared = 0, seed = 83026, n_start = 0, m_ctl, v, s, k;
  always #2 clk = ~clk;
  // Design and negotiation engine model.
  pbmc_top #(.LOOP_DEAD_CYCLES(20)) u_pbmc_top (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_en(tx_en), .an_speed_100(a100),
    .an_full_duplex(afull), .an_done(adone), .col(col), .phy_soft_reset(psr),
    .loopback(lb), .rx_dead(rxd), .speed_100(sp), .full_duplex(fd), .power_down(pd),
    .an_start(ans));
  pbmc_partner u_pbmc_partner (.clk(clk), .an_start(ans), .want_100(w100),
    .want_full(wfull), .an_speed_100(a100), .an_full_duplex(afull), .an_done(adone));
  // Counts negotiation starts.
  always @(posedge clk)
    if (ans === 1'b1) n_start++;
  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1
  // One classic cycle; holds the request until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Expected control read: negotiated speed and duplex when enabled.
  function automatic logic [31:0] exp_rd();
    logic [31:0] e;
    e = m_ctl;
    if (e[12])
    begin
      e[13] = w100;
      e[8] = wfull;
    end
    return e;
  endfunction : exp_rd
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Cuts a hang short.
  initial
  begin
    #80000;
    failures++;
    wrap_up();
  end
  // ==========================================================================
  // Scenarios
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk); // Lets the negotiated-result synchronisers fill.
    m_ctl = 32'h3100;
    wb(0, 8'h00, 0);
    chk("reset value", 32'h3100, rd);
    repeat (4)
    begin
      v = $random(seed) & 32'h6980;
      wb(1, 8'h00, v);
      m_ctl = v & 32'h7980;
      wb(0, 8'h00, 0);
      chk("forced ctl", exp_rd(), rd);
      chk1("speed pin", v[13], sp);
      chk1("duplex pin", v[8], fd);
      chk1("loop pin", v[14], lb);
      chk1("pdown pin", v[11], pd);
    end
    wb(1, 8'h00, 32'h2100);
    repeat (24) @(posedge clk);
    chk1("dead idle", 1'b0, rxd);
    wb(1, 8'h00, 32'h6100);
    repeat (3) @(posedge clk);
    chk1("dead time", 1'b1, rxd);
    repeat (30) @(posedge clk);
    chk1("dead over", 1'b0, rxd);
    m_ctl = 32'h1000;
    wb(1, 8'h00, m_ctl);
    for (int i = 0; i < 4; i++)
    begin
      w100 <= i[0];
      wfull <= ~i[1];
      repeat (6) @(posedge clk);
      wb(0, 8'h00, 0);
      chk("neg ctl", exp_rd(), rd);
      chk1("neg speed", w100, sp);
      chk1("neg duplex", wfull, fd);
    end
    wb(1, 8'h00, 32'h0200);
    s = n_start;
    repeat (20) @(posedge clk);
    chk("no start", s, n_start);
    for (int r = 0; r < 2; r++)
    begin
      s = n_start;
      wb(1, 8'h00, 32'h1200);
      if (r == 0) wb(0, 8'h00, 0);
      if (r == 0) chk("restart pending", exp_rd() | 32'h0200, rd);
      if (r == 1) wb(1, 8'h00, 32'h1000);
      repeat (20) @(posedge clk);
      chk("one start", s + 1, n_start);
      wb(0, 8'h00, 0);
      chk("restart clear", exp_rd(), rd);
    end
    wb(1, 8'h00, 32'h0080);
    tx_en <= 1'b1;
    repeat (5) @(posedge clk);
    chk1("col test", 1'b1, col);
    wb(1, 8'h00, 32'h4800);
    repeat (5) @(posedge clk);
    chk1("col normal", 1'b0, col);
    tx_en <= 1'b0;
    wb(1, 8'h00, 32'h8000);
    m_ctl = 32'h3100;
    wb(0, 8'h00, 0);
    chk("in reset", exp_rd() | 32'h8000, rd);
    chk1("reset busy", 1'b1, psr);
    chk1("loop restored", 1'b0, lb);
    k = 0;
    while (psr !== 1'b0 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 300) failures++;
    wb(0, 8'h00, 0);
    chk("after reset", exp_rd(), rd);
    wb(1, 8'h0C, 32'hFFFF);
    wb(0, 8'h0C, 0);
    chk("unmapped", 32'h0, rd);
    wrap_up();
  end
endmodule : pbmc_top_tb
`default_nettype wire
